// ===== logic/slm_pkg.sv
// Shared constants for the serial link mode and power control block.
// Assumes an 8-bit register port already decoded from the serial interface.
package slm_pkg;

    // Register addresses (12-bit register space).
    localparam logic [11:0] ADDR_SOFT_TRIG   = 12'h06c;
    localparam logic [11:0] ADDR_GLITCH_PWR  = 12'h29b;
    localparam logic [11:0] ADDR_MODE        = 12'h200;
    localparam logic [11:0] ADDR_LINK_EN     = 12'h201;
    localparam logic [11:0] ADDR_FORMAT      = 12'h202;
    localparam logic [11:0] ADDR_MF_LEN      = 12'h203;
    localparam logic [11:0] ADDR_LANE_CFG    = 12'h204;
    localparam logic [11:0] ADDR_CH_PAIR     = 12'h205;
    localparam logic [11:0] ADDR_CAL_CTRL    = 12'h206;
    localparam logic [11:0] ADDR_EMB         = 12'h207;
    localparam logic [11:0] ADDR_STATUS      = 12'h208;
    localparam logic [11:0] ADDR_LANE_STAT   = 12'h209;
    localparam logic [11:0] ADDR_DERIVED_K   = 12'h20a;

    // Reset values.
    localparam logic [7:0] GLITCH_RST   = 8'h04;
    localparam logic [7:0] FORMAT_RST   = 8'h00;
    localparam logic [7:0] MF_LEN_RST   = 8'h1f;
    localparam logic [1:0] CH_PAIR_RST  = 2'h3;
    localparam logic [7:0] EMB_RST      = 8'h01;

    // Field positions.
    localparam int CAL_EN_BIT    = 0;
    localparam int CAL_MODE_LO   = 1;
    localparam int TRIG_SEL_BIT  = 3;
    localparam int LP_SEL_BIT    = 4;
    localparam int ALT_BIT       = 0;
    localparam int SYNC_LO       = 1;

    // Lane and format limits.
    localparam int NUM_LANES       = 8;
    localparam int LANE_GROUP      = 4;
    localparam logic [7:0] FORMAT_MAX = 8'h0e;
    localparam logic [15:0] VALID_FORMATS = 16'h47ff;
    localparam logic [15:0] FORMATS_64B   = 16'h41f0;
    localparam logic [15:0] FORMATS_M_EQ_L = 16'h0060;
    localparam logic [15:0] LP_RATE_MAX_MHZ = 16'h03e8;

    // Multiblock size in octets and blocks; swap timing in sample clocks.
    localparam int K_BLOCK_OCTETS  = 8;
    localparam int K_BLOCKS        = 32;
    localparam int SWAP_MIN        = 500;
    localparam int SWAP_MAX        = 1000;
    localparam int SWAP_DELAY      = 750;
    localparam int BG_SWAP_PERIOD  = 2048;

    typedef enum logic [1:0] {CAL_FG, CAL_BG, CAL_LP_BG, CAL_RSVD} slm_cal_e;
    typedef enum logic [1:0] {SH_CRC12, SH_FEC, SH_CRC3, SH_RSVD} slm_sync_e;

endpackage : slm_pkg

// ===== logic/slm_mode_ctrl.sv
// Mode, lane, calibration-swap and power-down control for the link side.
// Assumes the register port is synchronous to clk and one access per cycle.
//
// How it works
// - Low-power mode takes effect only at sample rates up to 1 GSPS.
// - Reset values leave the device in high-performance mode.
// - Glitch-versus-power register at 0x29B is stored and read back; no logic uses it.
// - In low-power background calibration with trigger select set, core swap lands 500-1000 clocks after trigger.
// - Foreground calibration never swaps converter cores.
// - Lane alignment sequence only in 8B/10B formats; parameters always apply.
// - Link parameters derive from format selector; only listed values valid.
// - 8B/10B multiframe length must sit in the allowed range and step.
// - 64B/66B frames per multiframe equals 8*32*E/F, not programmable.
// - Marked formats report converter count equal to lane count.
// - Lowest-numbered needed lanes are used; the rest power down.
// - Tail bits are zero and samples go out MSB first.
// - Sync header supports CRC-12 or FEC; CRC-3 is refused.
// - Lane redundancy allowed only for formats of four lanes or fewer.
// - Alternate select picks lower or upper four lanes on formats of four lanes or fewer; wider formats use both groups.
// - Power-down pin or mode register disables the serial drivers.
// - Registers and calibration results survive power-down unchanged.
// - With link disabled the link block is reset, gated and powered down.
`timescale 1ns/1ps
module slm_mode_ctrl
    import slm_pkg::*;
#(
    parameter int KM_MIN       = 3,
    parameter int KM_MAX       = 255,
    parameter int KM_STEP      = 1,
    parameter int FRAME_OCTETS = 8
)(
    // Clock, reset and enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Register port
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [11:0] regAddr,
    input  wire logic [7:0]  regWrData,
    output logic      [7:0]  regRdData,
    // Pins and operating conditions
    input  wire logic        powerDownInput,
    input  wire logic        calibrationTriggerPin,
    input  wire logic [15:0] sampleRateMhz,
    // Sample formatting
    input  wire logic [11:0] sampleIn,
    output logic      [15:0] sampleOut,
    // Link block controls
    output logic [NUM_LANES-1:0] laneEnable,
    output logic             linkReset,
    output logic             linkClockEnable,
    output logic             ilasEnable,
    output logic             coreSwap,
    output logic             lowPowerActive,
    output logic [1:0]       channelPairOn,
    output logic [3:0]       reportedConverters
);

    logic [7:0]  glitchPower_r, format_r, mfLen_r, emb_r;
    logic [1:0]  mode_r, chPair_r;
    logic        linkEnable_r, linkEnablePrev_r, alt_r, calEn_r;
    logic        trigSel_r, lpSel_r;
    slm_cal_e    calMode_r;
    slm_sync_e   syncHdr_r;
    logic [7:0]  actFormat_r, actMfLen_r;
    logic        actAlt_r;
    logic [3:0]  lanesUsed;
    logic        is64b, rateOk, pdActive, cfgValid, kValid, altOk;
    logic [15:0] derivedK;
    logic [NUM_LANES-1:0] lowMask;
    logic [10:0] swapCnt_r;
    logic        swapArmed_r;
    logic [11:0] bgCnt_r;
    logic        softTrig, trigger;

    // Lanes needed per format for the quad-channel part.
    function automatic logic [3:0] lanes_for(input logic [7:0] fmt);
        unique case (fmt)
            8'h00, 8'h09, 8'h0a, 8'h0e: lanes_for = 4'h8;
            8'h01, 8'h06:               lanes_for = 4'h6;
            8'h02, 8'h03, 8'h07, 8'h08: lanes_for = 4'h4;
            8'h04:                      lanes_for = 4'h3;
            8'h05:                      lanes_for = 4'h2;
            default:                    lanes_for = 4'h0;
        endcase
    endfunction : lanes_for

    // Sample resolution per format.
    function automatic logic [3:0] bits_for(input logic [7:0] fmt);
        unique case (fmt)
            8'h02, 8'h05, 8'h07, 8'h09: bits_for = 4'h8;
            8'h03, 8'h0a:               bits_for = 4'ha;
            default:                    bits_for = 4'hc;
        endcase
    endfunction : bits_for

    // Register writes; none of these clear on power-down.
    // registers held through power-down
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            glitchPower_r <= GLITCH_RST;
            format_r      <= FORMAT_RST;
            mfLen_r       <= MF_LEN_RST;
            emb_r         <= EMB_RST;
            mode_r        <= 2'h0;
            chPair_r      <= CH_PAIR_RST;
            linkEnable_r  <= 1'b0;
            alt_r         <= 1'b0;
            syncHdr_r     <= SH_CRC12;
            calEn_r       <= 1'b0;
            calMode_r     <= CAL_FG;
            trigSel_r     <= 1'b0;
            lpSel_r       <= 1'b0;
        end
        else if (ce && regWr)
        begin
            unique case (regAddr)
                ADDR_GLITCH_PWR: glitchPower_r <= regWrData;
                ADDR_MODE:       mode_r <= regWrData[1:0];
                ADDR_LINK_EN:    linkEnable_r <= regWrData[0];
                ADDR_FORMAT:     format_r <= regWrData;
                ADDR_MF_LEN:     mfLen_r <= regWrData;
                ADDR_EMB:        emb_r <= regWrData;
                ADDR_CH_PAIR:    chPair_r <= regWrData[1:0];
                ADDR_LANE_CFG:
                begin
                    alt_r <= regWrData[ALT_BIT];
                    // CRC-3 and reserved codes leave the field alone
                    if (regWrData[SYNC_LO+1:SYNC_LO] == SH_CRC12 ||
                        regWrData[SYNC_LO+1:SYNC_LO] == SH_FEC)
                        syncHdr_r <= slm_sync_e'(
                            regWrData[SYNC_LO+1:SYNC_LO]);
                end
                ADDR_CAL_CTRL:
                begin
                    calEn_r   <= regWrData[CAL_EN_BIT];
                    calMode_r <= slm_cal_e'(
                        regWrData[CAL_MODE_LO+1:CAL_MODE_LO]);
                    trigSel_r <= regWrData[TRIG_SEL_BIT];
                    lpSel_r   <= regWrData[LP_SEL_BIT];
                end
                default: ;
            endcase
        end
    end

    assign softTrig = ce && regWr && regAddr == ADDR_SOFT_TRIG && regWrData[0];

    // active link settings latch only on link enable rise
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            linkEnablePrev_r <= 1'b0;
            actFormat_r      <= FORMAT_RST;
            actMfLen_r       <= MF_LEN_RST;
            actAlt_r         <= 1'b0;
        end
        else if (ce)
        begin
            linkEnablePrev_r <= linkEnable_r;
            if (linkEnable_r && !linkEnablePrev_r)
            begin
                actFormat_r <= format_r;
                actMfLen_r  <= mfLen_r;
                actAlt_r    <= alt_r;
            end
        end
    end

    // parameters derived from the format selector alone
    assign lanesUsed = lanes_for(actFormat_r);
    assign is64b     = FORMATS_64B[actFormat_r[3:0]];
    // multiframe length range and step in 8B/10B
    assign kValid    = is64b || (int'(actMfLen_r) >= KM_MIN &&
                       int'(actMfLen_r) <= KM_MAX &&
                       (int'(actMfLen_r) - KM_MIN) % KM_STEP == 0);
    assign cfgValid  = actFormat_r <= FORMAT_MAX &&
                       VALID_FORMATS[actFormat_r[3:0]] && kValid;
    // fixed frames per multiblock in 64B/66B
    assign derivedK  = is64b ? 16'((K_BLOCK_OCTETS * K_BLOCKS *
                       int'(emb_r)) / FRAME_OCTETS)
                       : {8'h00, actMfLen_r} + 16'h0001;
    assign ilasEnable = linkEnable_r && !is64b;
    // converter count reported as lane count in marked formats, four otherwise
    assign reportedConverters = FORMATS_M_EQ_L[actFormat_r[3:0]] ?
                                lanesUsed : 4'h4;

    // low-power only up to 1 GSPS
    assign rateOk = sampleRateMhz <= LP_RATE_MAX_MHZ;
    // lpSel resets low so high performance is the default
    assign lowPowerActive = lpSel_r && rateOk;

    // pin or mode register powers the device down
    assign pdActive = powerDownInput || mode_r != 2'h0;
    assign channelPairOn = pdActive ? 2'h0 : chPair_r;

    // link held in reset with clocks gated while disabled
    assign linkReset       = !linkEnable_r;
    assign linkClockEnable = linkEnable_r && !pdActive && cfgValid;

    // redundancy only for four lanes or fewer
    assign altOk = actAlt_r && lanesUsed <= 4'(LANE_GROUP);

    // one enable per lane, lowest-numbered first
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LANES; gi++)
        begin : g_lane
            assign lowMask[gi] = gi < int'(lanesUsed);
            // upper group alone when alternate select is set on four lanes or fewer
            assign laneEnable[gi] = linkClockEnable &&
                (altOk ? (gi >= LANE_GROUP && lowMask[gi-LANE_GROUP+
                          (gi >= LANE_GROUP ? 0 : LANE_GROUP)])
                       : lowMask[gi]);
        end
    endgenerate

    // MSB first, zero tail bits below the sample
    always_ff @(posedge clk)
    begin
        if (rst)
            sampleOut <= 16'h0000;
        else if (ce)
            sampleOut <= {sampleIn >> (4'hc - bits_for(actFormat_r)), 4'h0}
                         << (4'hc - bits_for(actFormat_r));
    end

    // triggered swap in low-power background calibration
    assign trigger = (calibrationTriggerPin || softTrig) && calEn_r &&
                     calMode_r == CAL_LP_BG && trigSel_r && !pdActive;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            swapArmed_r <= 1'b0;
            swapCnt_r   <= 11'h000;
            bgCnt_r     <= 12'h000;
            coreSwap    <= 1'b0;
        end
        else if (ce)
        begin
            coreSwap <= 1'b0;
            if (trigger && !swapArmed_r)
            begin
                swapArmed_r <= 1'b1;
                swapCnt_r   <= 11'h000;
            end
            else if (swapArmed_r)
            begin
                swapCnt_r <= swapCnt_r + 11'h001;
                if (int'(swapCnt_r) == SWAP_DELAY - 2)
                begin
                    swapArmed_r <= 1'b0;
                    coreSwap    <= 1'b1;
                end
            end
            // Untriggered background calibration swaps on its own period.
            // foreground mode never reaches this branch
            if (calEn_r && !pdActive && (calMode_r == CAL_BG ||
                (calMode_r == CAL_LP_BG && !trigSel_r)))
            begin
                bgCnt_r <= bgCnt_r + 12'h001;
                if (int'(bgCnt_r) == BG_SWAP_PERIOD - 1)
                begin
                    bgCnt_r  <= 12'h000;
                    coreSwap <= 1'b1;
                end
            end
            else
                bgCnt_r <= 12'h000;
        end
    end

    // Read data is registered; unmapped addresses read zero.
    always_ff @(posedge clk)
    begin
        if (rst)
            regRdData <= 8'h00;
        else if (ce && regRd)
        begin
            unique case (regAddr)
                ADDR_GLITCH_PWR: regRdData <= glitchPower_r;
                ADDR_MODE:       regRdData <= {6'h00, mode_r};
                ADDR_LINK_EN:    regRdData <= {7'h00, linkEnable_r};
                ADDR_FORMAT:     regRdData <= format_r;
                ADDR_MF_LEN:     regRdData <= mfLen_r;
                ADDR_EMB:        regRdData <= emb_r;
                ADDR_CH_PAIR:    regRdData <= {6'h00, chPair_r};
                ADDR_LANE_CFG:   regRdData <= {5'h00, syncHdr_r, alt_r};
                ADDR_CAL_CTRL:   regRdData <= {3'h0, lpSel_r, trigSel_r,
                                               calMode_r, calEn_r};
                ADDR_STATUS:     regRdData <= {2'h0, altOk, lowPowerActive,
                                    is64b, pdActive, cfgValid,
                                    linkClockEnable};
                ADDR_LANE_STAT:  regRdData <= laneEnable;
                ADDR_DERIVED_K:  regRdData <= derivedK[7:0];
                default:         regRdData <= 8'h00;
            endcase
        end
    end

    // Checks.
    sequence s_trig;
        trigger && !swapArmed_r && ce;
    endsequence

    sequence s_swap_window;
        ##[500:1000] coreSwap;
    endsequence

    a_hp_default: assert property (@(posedge clk)
        rst |=> !lowPowerActive)
        else $error("not in high-performance mode after reset");

    a_lp_rate: assert property (@(posedge clk) disable iff (rst)
        lowPowerActive |-> sampleRateMhz <= LP_RATE_MAX_MHZ)
        else $error("low-power mode above rate limit");

    a_swap_window: assert property (@(posedge clk) disable iff (rst)
        s_trig ##1 ce[*8] |-> s_swap_window)
        else $error("triggered swap outside window");

    a_fg_noswap: assert property (@(posedge clk) disable iff (rst)
        calMode_r == CAL_FG && $past(calMode_r) == CAL_FG
        && !swapArmed_r |=> !coreSwap)
        else $error("core swap in foreground mode");

    a_lane_lowest: assert property (@(posedge clk) disable iff (rst)
        linkClockEnable && !altOk |-> laneEnable == lowMask)
        else $error("lanes not lowest-numbered");

    a_alt_upper: assert property (@(posedge clk) disable iff (rst)
        laneEnable[7:4] == 4'h0 || laneEnable[3:0] == 4'h0
        || lanesUsed > 4'(LANE_GROUP))
        else $error("both lane groups active");

    a_pd_lanes: assert property (@(posedge clk) disable iff (rst)
        pdActive |-> laneEnable == '0 && channelPairOn == 2'h0)
        else $error("drivers on during power-down");

    a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
        linkEnablePrev_r && $past(linkEnablePrev_r) |-> $stable(actFormat_r))
        else $error("format changed while link enabled");

    a_crc3_refused: assert property (@(posedge clk) disable iff (rst)
        syncHdr_r == SH_CRC12 || syncHdr_r == SH_FEC)
        else $error("unsupported sync header mode");

    a_link_off: assert property (@(posedge clk) disable iff (rst)
        !linkEnable_r |-> linkReset && !linkClockEnable && laneEnable == '0)
        else $error("link active while disabled");

endmodule : slm_mode_ctrl

// ===== bench/slm_link_rx_model.sv
// Far-end link receiver model that gathers the block's lane streams.
// Assumes it shares the sample clock and sees the block's lane enables.
`timescale 1ns/1ps
module slm_link_rx_model
#(
    parameter int FLUSH_CYCLES = 64
)(
    // Clock
    input  wire logic        clk,
    // Link side
    input  wire logic [7:0]  laneEnable,
    input  wire logic        linkClockEnable,
    input  wire logic [15:0] sampleOut,
    // Rebuilt stream
    output logic             rxValid,
    output logic      [15:0] rxSample,
    output logic      [2:0]  rxLane
);
    logic [7:0] flushCnt_r;

    // relink then flush
    // Stale pipeline content is dropped; a larger count models a slow end.
    always_ff @(posedge clk)
    begin
        if (!linkClockEnable)
            flushCnt_r <= 8'(FLUSH_CYCLES);
        else if (flushCnt_r != 8'h00)
            flushCnt_r <= flushCnt_r - 8'h01;
    end

    always_ff @(posedge clk)
    begin
        rxValid  <= linkClockEnable && (flushCnt_r == 8'h00);
        rxSample <= sampleOut;
        if (!linkClockEnable || int'(rxLane) + 1 >= $countones(laneEnable))
            rxLane <= 3'h0;
        else
            rxLane <= rxLane + 3'h1;
    end
endmodule : slm_link_rx_model

// ===== bench/serial_link_mode_and_power_control_test.sv
// Self-checking bench for the link mode and power control block.
// Assumes the block's package and the receiver model are compiled first.
`timescale 1ns/1ps
module serial_link_mode_and_power_control_test;
    import slm_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [7:0]  regWrData = 8'h00;
    logic        powerDownInput = 1'b0;
    logic        calibrationTriggerPin = 1'b0;
    logic [15:0] sampleRateMhz = 16'h03e8;
    logic [11:0] sampleIn = 12'h000;
    logic [7:0]  regRdData;
    logic [15:0] sampleOut;
    logic [7:0]  laneEnable;
    logic        linkReset, linkClockEnable, ilasEnable, coreSwap;
    logic        lowPowerActive, rxValid;
    logic [1:0]  channelPairOn;
    logic [3:0]  reportedConverters;
    logic [15:0] rxSample, rnd = 16'h0010, rate;
    logic [2:0]  rxLane;
    logic [11:0] prevIn;
    logic [7:0]  expQ[$];
    logic        rdV = 1'b0;
    int          errCount = 0;
    int          nCompared = 0;
    int          n, seen;
    // Lanes used per output format on the quad device; zero marks invalid.
    int laneCnt [16] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 0, 0, 0, 8, 0};
    // Tail bits below each format's resolution must come out as zero.
    logic [7:0]  fmtSeq [3] = '{8'h02, 8'h03, 8'h00};
    logic [15:0] keepMask [3] = '{16'hff00, 16'hffc0, 16'hfff0};

    always #2 clk = ~clk;

    slm_mode_ctrl i_dut (
        .clk(clk), .rst(rst), .ce(ce), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .powerDownInput(powerDownInput),
        .calibrationTriggerPin(calibrationTriggerPin),
        .sampleRateMhz(sampleRateMhz), .sampleIn(sampleIn),
        .sampleOut(sampleOut), .laneEnable(laneEnable),
        .linkReset(linkReset), .linkClockEnable(linkClockEnable),
        .ilasEnable(ilasEnable), .coreSwap(coreSwap),
        .lowPowerActive(lowPowerActive), .channelPairOn(channelPairOn),
        .reportedConverters(reportedConverters));

    slm_link_rx_model i_rx (
        .clk(clk), .laneEnable(laneEnable),
        .linkClockEnable(linkClockEnable), .sampleOut(sampleOut),
        .rxValid(rxValid), .rxSample(rxSample), .rxLane(rxLane));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic conclude();
        if (errCount == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic cmp_port(input string nm, input logic [15:0] e,
                            input logic [15:0] g);
        nCompared++;
        if (g !== e)
        begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_port

    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
        cmp_port("regRdData", 16'(e), 16'(g));
    endtask : cmp_rd

    // A read taken at a rising edge is checked at the next falling edge,
    // where the registered read data has settled.
    always @(posedge clk)
        rdV <= regRd && ce;

    always @(negedge clk)
    begin
        if (rdV)
            cmp_rd(expQ.pop_front(), regRdData);
    end

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Configuration is only changed with the link held off.
    task automatic link(input logic [7:0] fmt, input logic alt);
        wr(ADDR_LINK_EN, 8'h00);
        wr(ADDR_FORMAT, fmt);
        wr(ADDR_LANE_CFG, {7'h00, alt});
        wr(ADDR_LINK_EN, 8'h01);
        settle(2);
    endtask : link

    task automatic wait_swap();
        n = 0;
        while (coreSwap !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 1200)
            begin
                errCount++;
                conclude();
            end
        end
        cmp_port("swapDelay", 16'h0001, 16'(n >= 500 && n <= 1000));
    endtask : wait_swap

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        cmp_port("lowPowerActive", 16'h0000, 16'(lowPowerActive));
        cmp_port("linkReset", 16'h0001, 16'(linkReset));
        cmp_port("laneEnable", 16'h0000, 16'(laneEnable));
        rd(ADDR_GLITCH_PWR, 8'h04);
        rd(ADDR_FORMAT, 8'h00);
        rd(ADDR_MF_LEN, 8'h1f);
        rd(ADDR_SOFT_TRIG, 8'h00);
        rd(12'h3ff, 8'h00);
        wr(ADDR_GLITCH_PWR, 8'h07);
        rd(ADDR_GLITCH_PWR, 8'h07);
        wr(ADDR_LANE_CFG, 8'h02);
        rd(ADDR_LANE_CFG, 8'h02);
        wr(ADDR_LANE_CFG, 8'h04);
        rd(ADDR_LANE_CFG, 8'h02);
        for (int f = 0; f < 16; f++)
        begin
            link(8'(f), 1'b0);
            cmp_port("laneEnable", 16'((1 << laneCnt[f]) - 1),
                     16'(laneEnable));
            cmp_port("linkClockEnable", 16'(laneCnt[f] != 0),
                     16'(linkClockEnable));
            if (laneCnt[f] != 0)
            begin
                cmp_port("ilasEnable", 16'(!FORMATS_64B[f]),
                         16'(ilasEnable));
                cmp_port("reportedConverters", 16'(FORMATS_M_EQ_L[f] ?
                         laneCnt[f] : 4), 16'(reportedConverters));
            end
        end
        link(8'h02, 1'b1);
        cmp_port("laneEnable", 16'h00f0, 16'(laneEnable));
        wr(ADDR_FORMAT, 8'h00);
        settle(2);
        cmp_port("laneEnable", 16'h00f0, 16'(laneEnable));
        link(8'h00, 1'b1);
        cmp_port("laneEnable", 16'h00ff, 16'(laneEnable));
        // K is 8 * 32 * E / F with E = 2 and eight octets per frame.
        wr(ADDR_EMB, 8'h02);
        link(8'h0e, 1'b0);
        rd(ADDR_DERIVED_K, 8'h40);
        foreach (fmtSeq[j])
        begin
            link(fmtSeq[j], 1'b0);
            for (int i = 0; i < 16; i++)
            begin
                @(posedge clk);
                prevIn = sampleIn;
                rnd = lfsr(rnd);
                sampleIn <= rnd[11:0];
                @(negedge clk);
                cmp_port("sampleOut", {prevIn, 4'h0} & keepMask[j],
                         sampleOut);
            end
        end
        rd(ADDR_DERIVED_K, 8'h20);
        @(posedge clk);
        powerDownInput <= 1'b1;
        settle(2);
        cmp_port("laneEnable", 16'h0000, 16'(laneEnable));
        cmp_port("channelPairOn", 16'h0000, 16'(channelPairOn));
        @(posedge clk);
        powerDownInput <= 1'b0;
        settle(2);
        cmp_port("laneEnable", 16'h00ff, 16'(laneEnable));
        // receiver drops output while pipelines flush
        cmp_port("rxValid", 16'h0000, 16'(rxValid));
        settle(64);
        cmp_port("rxValid", 16'h0001, 16'(rxValid));
        rd(ADDR_GLITCH_PWR, 8'h07);
        // A write made while the clock enable is low must be lost.
        ce <= 1'b0;
        wr(ADDR_GLITCH_PWR, 8'h55);
        ce <= 1'b1;
        rd(ADDR_GLITCH_PWR, 8'h07);
        wr(ADDR_MODE, 8'h01);
        settle(2);
        cmp_port("laneEnable", 16'h0000, 16'(laneEnable));
        wr(ADDR_MODE, 8'h00);
        wr(ADDR_LINK_EN, 8'h00);
        wr(ADDR_CAL_CTRL, 8'h00);
        wr(ADDR_CAL_CTRL, 8'h10);
        for (int i = 0; i < 10; i++)
        begin
            rnd = lfsr(rnd);
            rate = (i < 2) ? 16'h03e8 + 16'(i) : {5'h00, rnd[10:0]};
            @(posedge clk);
            sampleRateMhz <= rate;
            settle(2);
            cmp_port("lowPowerActive", 16'(rate <= 16'h03e8),
                     16'(lowPowerActive));
        end
        wr(ADDR_CAL_CTRL, 8'h0d);
        wr(ADDR_SOFT_TRIG, 8'h01);
        wait_swap();
        @(posedge clk);
        calibrationTriggerPin <= 1'b1;
        @(posedge clk);
        calibrationTriggerPin <= 1'b0;
        wait_swap();
        wr(ADDR_CAL_CTRL, 8'h01);
        seen = 0;
        repeat (2100)
        begin
            @(negedge clk);
            seen += int'(coreSwap === 1'b1);
        end
        cmp_port("coreSwap", 16'h0000, 16'(seen));
        settle(4);
        conclude();
    end
endmodule : serial_link_mode_and_power_control_test
